//--- inc/sps_pkg.sv
// package: constants and types shared by the sdram device model and controller
`default_nettype none
package sps_pkg;
   // command encodings {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_NOP = 4'b0111;
   localparam logic [3:0] CMD_ACT = 4'b0011;
   localparam logic [3:0] CMD_RD = 4'b0101;
   localparam logic [3:0] CMD_WR = 4'b0100;
   localparam logic [3:0] CMD_PRE = 4'b0010;
   localparam logic [3:0] CMD_REF = 4'b0001;
   localparam logic [3:0] CMD_BST = 4'b0110;
   localparam logic [3:0] CMD_MRS = 4'b0000;
   // address field positions
   localparam int ADDR_W = 13;
   localparam int ALL_BANK_BIT = 10;
   localparam int AP_BIT = 10;
   localparam int WBM_BIT = 9;
   localparam int COL_W = 10;
   // timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int PRECHARGE_TIME_NS = 20;
   localparam int PRECHARGE_CYC = (PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
   localparam int WRITE_RECOVERY_NS = 15;
   localparam int WRITE_RECOVERY_CYC = (WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS + 1;
   localparam int DS_EXIT_NOP_US = 100;
   localparam int DS_EXIT_CYC = (DS_EXIT_NOP_US * 1000 + CLK_PERIOD_NS - 1)
                                / CLK_PERIOD_NS;
   localparam int REFRESH_PERIOD_MS = 64;
   localparam int REFRESH_PERIOD_CYC = REFRESH_PERIOD_MS * 1000000
                                       / CLK_PERIOD_NS;
   localparam int EXIT_REFRESHES = 2;
   localparam int READ_LATENCY = 2;
   localparam int BURST_LENGTH = 4;
   // avalon register offsets (controller)
   localparam logic [3:0] REG_CMD = 4'h0;
   localparam logic [3:0] REG_ADDR = 4'h4;
   localparam logic [3:0] REG_WDATA = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hc;
   localparam logic [3:0] REG_RDATA = 4'h0;
   // controller operation codes in REG_CMD[3:0]
   localparam logic [3:0] OP_ACT = 4'h1;
   localparam logic [3:0] OP_RD = 4'h2;
   localparam logic [3:0] OP_WR = 4'h3;
   localparam logic [3:0] OP_PRE = 4'h4;
   localparam logic [3:0] OP_REF = 4'h5;
   localparam logic [3:0] OP_PD = 4'h6;
   localparam logic [3:0] OP_WAKE = 4'h7;
   localparam logic [3:0] OP_DS = 4'h8;
   localparam logic [3:0] OP_NOP = 4'h9;
   localparam logic [3:0] OP_SUSP = 4'ha;
   localparam logic [3:0] OP_MODE = 4'hb;
   // per-bank state
   typedef enum logic [1:0] {
      BK_IDLE = 2'b00,
      BK_ACTIVE = 2'b01,
      BK_READ = 2'b10,
      BK_WRITE = 2'b11
   } sps_bank_e;
   // device power state
   typedef enum logic [1:0] {
      PW_RUN = 2'b00,
      PW_DOWN = 2'b01,
      PW_SUSP = 2'b10,
      PW_DEEP = 2'b11
   } sps_pwr_e;
endpackage
`default_nettype wire

//--- inc/sps_if.sv
// interface: sdram pins between controller and device
`default_nettype none
interface sps_if #(parameter int DW = 16);
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic [1:0] bank_sel;
   logic [12:0] addr;
   logic dqm;
   logic [DW-1:0] dq_to_dev;
   logic [DW-1:0] dq_from_dev;
   logic dq_oe_n;
   modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, bank_sel, addr, dqm,
                 dq_to_dev, input dq_from_dev, dq_oe_n);
   modport dev (input cke, cs_n, ras_n, cas_n, we_n, bank_sel, addr, dqm,
                dq_to_dev, output dq_from_dev, dq_oe_n);
endinterface
`default_nettype wire

//--- design/sps_device.sv
// design: four-bank sdram device, precharge, power states and auto-precharge
// Overview of operation
// R1 - precharge closes one bank or all banks
// R2 - precharged bank idle, activate after precharge time
// R3 - low clock enable with nop enters power-down
// R4 - power-down precharge variant or active variant
// R5 - powered down: buffers off, no refresh
// R6 - controller limits power-down to 64 ms; the code only sets pd_overrun_r, power-down goes on
// R7 - nop with clock enable high exits power-down
// R8 - deep sleep entry: idle, cke low, burst-stop
// R9 - deep sleep loses memory array contents
// R10 - controller holds clock enable low in deep sleep
// R11 - clock stable before raising clock enable
// R12 - deep sleep exit: 100 us nop, precharge, refreshes
// R13 - mode registers kept across deep sleep
// R14 - cke low during burst enters clock suspend
// R15 - suspended edges ignored, outputs held, counters hold
// R16 - cke high resumes internal clock next edge
// R17 - write-burst mode bit makes single writes
// R18 - other-bank access during auto-precharge allowed
// R19 - read interrupts auto-precharge read, latency later
// R20 - write interrupts auto-precharge read, mask early
// R21 - read interrupts auto-precharge write, recovery from read
// R22 - write interrupts auto-precharge write, recovery from write
// R23 - power-down exit leaves banks idle next edge
// R24 - per-bank state decides power-down or suspend
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`default_nettype none
module sps_device #(
   parameter int DW = 16,
   parameter int MEM_WORDS = 64
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // sdram pins
   sps_if.dev pins,
   // observation
   output logic [1:0] pwr_state,
   output logic [7:0] bank_state,
   output logic power_down_active,
   output logic array_lost
);
   localparam int AW = $clog2(MEM_WORDS);
   localparam int PW = 4;
   logic [DW-1:0] mem [MEM_WORDS];
   sps_pkg::sps_bank_e bank_r [4];
   logic [3:0] ap_r;
   logic [PW-1:0] pre_cnt_r [4];
   logic [PW-1:0] wr_cnt_r [4];
   logic [12:0] mode_r;
   sps_pkg::sps_pwr_e pwr_r;
   logic cke_d_r;
   logic [1:0] burst_bank_r;
   logic [2:0] burst_left_r;
   logic [AW-1:0] col_r;
   logic rd_burst_r;
   logic wr_burst_r;
   logic [DW-1:0] rd_pipe_r [sps_pkg::READ_LATENCY];
   logic [sps_pkg::READ_LATENCY-1:0] rd_vld_r;
   logic [sps_pkg::READ_LATENCY-1:0] dqm_pipe_r;
   logic dq_oe_n_r;
   logic [DW-1:0] dq_out_r;
   logic lost_r;
   logic [3:0] cmd;
   logic run;
   logic any_active;
   logic any_burst;
   always_comb begin
      cmd = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
      if (pins.cs_n) begin
         cmd = sps_pkg::CMD_NOP;
      end
      any_active = 1'b0;
      for (int b = 0; b < 4; b++) begin
         if (bank_r[b] != sps_pkg::BK_IDLE || pre_cnt_r[b] != '0) begin
            any_active = 1'b1;
         end
      end
      any_burst = rd_burst_r | wr_burst_r | (|rd_vld_r);
      // commands are registered only at unsuspended edges in run state
      run = (pwr_r == sps_pkg::PW_RUN) && pins.cke && cke_d_r; // R15
   end
   // power state tracking
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         pwr_r <= sps_pkg::PW_RUN;
         cke_d_r <= 1'b1;
         lost_r <= 1'b0;
      end else begin
         cke_d_r <= pins.cke;
         case (pwr_r)
            sps_pkg::PW_RUN: begin
               if (!pins.cke && any_burst) begin
                  pwr_r <= sps_pkg::PW_SUSP; // R14 R24
               end else if (!pins.cke && !any_active
                            && cmd == sps_pkg::CMD_BST) begin
                  pwr_r <= sps_pkg::PW_DEEP; // R8
                  lost_r <= 1'b1; // R9
               end else if (!pins.cke && cmd == sps_pkg::CMD_NOP) begin
                  pwr_r <= sps_pkg::PW_DOWN; // R3 R4
               end
            end
            sps_pkg::PW_DOWN: begin
               if (pins.cke && cmd == sps_pkg::CMD_NOP) begin
                  pwr_r <= sps_pkg::PW_RUN; // R7 R23
               end
            end
            sps_pkg::PW_SUSP: begin
               if (pins.cke) begin
                  pwr_r <= sps_pkg::PW_RUN; // R16
               end
            end
            sps_pkg::PW_DEEP: begin
               if (pins.cke) begin
                  pwr_r <= sps_pkg::PW_RUN; // R12
               end
            end
            default: pwr_r <= sps_pkg::PW_RUN;
         endcase
      end
   end
   // mode register survives deep sleep: no reset path other than nrst
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         mode_r <= '0;
      end else if (run && cmd == sps_pkg::CMD_MRS) begin
         mode_r <= pins.addr; // R13
      end
   end
   // per-bank state, precharge and write recovery counters
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         for (int b = 0; b < 4; b++) begin
            bank_r[b] <= sps_pkg::BK_IDLE;
            pre_cnt_r[b] <= '0;
            wr_cnt_r[b] <= '0;
         end
         ap_r <= '0;
      end else if (pwr_r == sps_pkg::PW_DEEP) begin
         for (int b = 0; b < 4; b++) begin
            bank_r[b] <= sps_pkg::BK_IDLE;
         end
      end else if (run) begin
         for (int b = 0; b < 4; b++) begin
            if (pre_cnt_r[b] != '0) begin
               pre_cnt_r[b] <= pre_cnt_r[b] - 1'b1; // R2
            end
            if (wr_cnt_r[b] != '0) begin
               wr_cnt_r[b] <= wr_cnt_r[b] - 1'b1;
               if (wr_cnt_r[b] == PW'(1)) begin
                  bank_r[b] <= sps_pkg::BK_IDLE; // R21 R22
                  pre_cnt_r[b] <= PW'(sps_pkg::PRECHARGE_CYC);
               end
            end
         end
         case (cmd)
            sps_pkg::CMD_PRE: begin
               for (int b = 0; b < 4; b++) begin
                  if (pins.addr[sps_pkg::ALL_BANK_BIT]
                      || pins.bank_sel == 2'(b)) begin // R1
                     bank_r[b] <= sps_pkg::BK_IDLE;
                     ap_r[b] <= 1'b0;
                     pre_cnt_r[b] <= PW'(sps_pkg::PRECHARGE_CYC); // R2
                  end
               end
            end
            sps_pkg::CMD_ACT: begin
               if (pre_cnt_r[pins.bank_sel] == '0) begin // R2
                  bank_r[pins.bank_sel] <= sps_pkg::BK_ACTIVE;
               end
            end
            sps_pkg::CMD_RD, sps_pkg::CMD_WR: begin
               // other bank running auto-precharge is interrupted
               for (int b = 0; b < 4; b++) begin
                  if (ap_r[b] && 2'(b) != pins.bank_sel
                      && wr_cnt_r[b] == '0) begin // R18
                     ap_r[b] <= 1'b0;
                     if (bank_r[b] == sps_pkg::BK_READ) begin
                        bank_r[b] <= sps_pkg::BK_IDLE; // R19 R20
                        pre_cnt_r[b] <= PW'(sps_pkg::PRECHARGE_CYC);
                     end else begin
                        wr_cnt_r[b] <= PW'(sps_pkg::WRITE_RECOVERY_CYC);
                     end
                  end
               end
               if (bank_r[pins.bank_sel] != sps_pkg::BK_IDLE) begin // R2
                  bank_r[pins.bank_sel] <= (cmd == sps_pkg::CMD_RD)
                     ? sps_pkg::BK_READ : sps_pkg::BK_WRITE;
                  ap_r[pins.bank_sel] <= pins.addr[sps_pkg::AP_BIT];
               end
            end
            default: begin
               if (!any_burst) begin
                  for (int b = 0; b < 4; b++) begin
                     if (bank_r[b] == sps_pkg::BK_READ
                         || bank_r[b] == sps_pkg::BK_WRITE) begin
                        bank_r[b] <= ap_r[b] ? sps_pkg::BK_IDLE
                                             : sps_pkg::BK_ACTIVE;
                        if (ap_r[b]) begin
                           pre_cnt_r[b] <= PW'(sps_pkg::PRECHARGE_CYC);
                        end
                        ap_r[b] <= 1'b0;
                     end
                  end
               end
            end
         endcase
      end
   end
   // burst engine; counters freeze while suspended
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         rd_burst_r <= 1'b0;
         wr_burst_r <= 1'b0;
         burst_left_r <= '0;
         burst_bank_r <= '0;
         col_r <= '0;
      end else if (run) begin // R15
         if ((cmd == sps_pkg::CMD_RD || cmd == sps_pkg::CMD_WR)
             && bank_r[pins.bank_sel] != sps_pkg::BK_IDLE) begin
            rd_burst_r <= (cmd == sps_pkg::CMD_RD);
            wr_burst_r <= (cmd == sps_pkg::CMD_WR)
                          && !mode_r[sps_pkg::WBM_BIT]; // R17
            burst_bank_r <= pins.bank_sel;
            burst_left_r <= 3'(sps_pkg::BURST_LENGTH - 1);
            col_r <= AW'(pins.addr[AW-1:0] + 1'b1);
         end else if (cmd == sps_pkg::CMD_BST || cmd == sps_pkg::CMD_PRE
                      || burst_left_r == 3'd1) begin
            rd_burst_r <= 1'b0;
            wr_burst_r <= 1'b0;
            burst_left_r <= '0;
         end else if (burst_left_r != '0) begin
            burst_left_r <= burst_left_r - 1'b1;
            col_r <= col_r + 1'b1;
         end
      end
   end
   // array writes: first beat with the command, later beats from the burst
   always_ff @(posedge ref_clk) begin
      if (run && !pins.dqm) begin
         if (cmd == sps_pkg::CMD_WR
             && bank_r[pins.bank_sel] != sps_pkg::BK_IDLE) begin
            mem[pins.addr[AW-1:0]] <= pins.dq_to_dev;
         end else if (wr_burst_r && cmd == sps_pkg::CMD_NOP) begin
            mem[col_r] <= pins.dq_to_dev; // R22
         end
      end
   end
   // read pipeline, read_latency stages; frozen during suspend
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         rd_vld_r <= '0;
         dqm_pipe_r <= '0;
         dq_oe_n_r <= 1'b1;
         dq_out_r <= '0;
         for (int i = 0; i < sps_pkg::READ_LATENCY; i++) begin
            rd_pipe_r[i] <= '0;
         end
      end else if (pwr_r == sps_pkg::PW_DOWN || pwr_r == sps_pkg::PW_DEEP) begin
         dq_oe_n_r <= 1'b1; // R5
         rd_vld_r <= '0;
      end else if (run) begin
         rd_vld_r <= {rd_vld_r[sps_pkg::READ_LATENCY-2:0],
                      (cmd == sps_pkg::CMD_RD) || (rd_burst_r
                      && cmd == sps_pkg::CMD_NOP)}; // R19
         dqm_pipe_r <= {dqm_pipe_r[sps_pkg::READ_LATENCY-2:0], pins.dqm};
         rd_pipe_r[0] <= (cmd == sps_pkg::CMD_RD)
                         ? mem[pins.addr[AW-1:0]] : mem[col_r];
         for (int i = 1; i < sps_pkg::READ_LATENCY; i++) begin
            rd_pipe_r[i] <= rd_pipe_r[i-1];
         end
         // write registered cuts read data at once
         dq_oe_n_r <= !(rd_vld_r[sps_pkg::READ_LATENCY-1]
                        && !dqm_pipe_r[sps_pkg::READ_LATENCY-1]
                        && cmd != sps_pkg::CMD_WR); // R20
         dq_out_r <= rd_pipe_r[sps_pkg::READ_LATENCY-1];
      end
   end
   // observation outputs
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         pwr_state <= sps_pkg::PW_RUN;
         bank_state <= '0;
         power_down_active <= 1'b0;
         array_lost <= 1'b0;
      end else begin
         pwr_state <= pwr_r;
         bank_state <= {bank_r[3], bank_r[2], bank_r[1], bank_r[0]};
         power_down_active <= (pwr_r == sps_pkg::PW_DOWN) && any_active; // R4
         array_lost <= lost_r;
      end
   end
   assign pins.dq_from_dev = dq_out_r;
   assign pins.dq_oe_n = dq_oe_n_r;
endmodule // sps_device
`default_nettype wire

//--- design/sps_ctrl.sv
// design: sdram controller end, driven by software over avalon-mm
`default_nettype none
module sps_ctrl #(
   parameter int DW = 16,
   parameter int DS_EXIT_CYC = sps_pkg::DS_EXIT_CYC,
   parameter int REFRESH_PERIOD_CYC = sps_pkg::REFRESH_PERIOD_CYC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // avalon-mm slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // sdram pins
   sps_if.ctrl pins
);
   logic [31:0] addr_r;
   logic [DW-1:0] wdata_r;
   logic [DW-1:0] rdata_r;
   logic cke_r;
   logic [3:0] cmd_r;
   logic [1:0] bank_r;
   logic [12:0] a_r;
   logic dqm_r;
   logic [DW-1:0] dq_r;
   logic deep_r;
   logic pd_r;
   logic busy_r;
   logic [31:0] wait_r;
   logic [31:0] pd_cnt_r;
   logic pd_overrun_r;
   logic ack_r;
   logic [3:0] op;
   always_comb begin
      op = avs_writedata[3:0];
   end
   // bus handshake: one wait cycle, answer at the second edge
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         ack_r <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata <= '0;
      end else begin
         ack_r <= (avs_read || avs_write) && !ack_r && !busy_r;
         avs_waitrequest <= !((avs_read || avs_write) && !ack_r && !busy_r);
         if (avs_read && !ack_r) begin
            case (avs_address)
               sps_pkg::REG_RDATA: avs_readdata <= 32'(rdata_r);
               sps_pkg::REG_ADDR: avs_readdata <= addr_r;
               sps_pkg::REG_WDATA: avs_readdata <= 32'(wdata_r);
               sps_pkg::REG_STATUS: avs_readdata <= {28'h000_0000,
                  pd_overrun_r, busy_r, pd_r, deep_r};
               default: avs_readdata <= 32'h0000_0000;
            endcase
         end
      end
   end
   // data registers; a write lands at the edge that sees waitrequest low
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         addr_r <= '0;
         wdata_r <= '0;
      end else if (avs_write && ack_r) begin
         if (avs_address == sps_pkg::REG_ADDR) begin
            addr_r <= avs_writedata;
         end
         if (avs_address == sps_pkg::REG_WDATA) begin
            wdata_r <= avs_writedata[DW-1:0];
         end
      end
   end
   // command sequencer: one pin command per software op
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         cke_r <= 1'b1;
         cmd_r <= sps_pkg::CMD_NOP;
         bank_r <= '0;
         a_r <= '0;
         dqm_r <= 1'b0;
         dq_r <= '0;
         deep_r <= 1'b0;
         pd_r <= 1'b0;
         busy_r <= 1'b0;
         wait_r <= '0;
      end else begin
         cmd_r <= sps_pkg::CMD_NOP;
         if (wait_r != '0) begin
            wait_r <= wait_r - 1'b1; // R12
            busy_r <= (wait_r != 32'h0000_0001);
         end
         if (avs_write && ack_r && !busy_r
             && avs_address == sps_pkg::REG_CMD) begin
            bank_r <= addr_r[14:13];
            a_r <= addr_r[12:0];
            dqm_r <= avs_writedata[4]; // R20
            case (op)
               sps_pkg::OP_ACT: cmd_r <= sps_pkg::CMD_ACT;
               sps_pkg::OP_RD: cmd_r <= sps_pkg::CMD_RD;
               sps_pkg::OP_WR: begin
                  cmd_r <= sps_pkg::CMD_WR;
                  dq_r <= wdata_r;
               end
               sps_pkg::OP_PRE: cmd_r <= sps_pkg::CMD_PRE; // R1
               sps_pkg::OP_REF: cmd_r <= sps_pkg::CMD_REF;
               sps_pkg::OP_MODE: cmd_r <= sps_pkg::CMD_MRS;
               sps_pkg::OP_PD: begin
                  cke_r <= 1'b0; // R3
                  pd_r <= 1'b1;
               end
               sps_pkg::OP_SUSP: cke_r <= 1'b0; // R14
               sps_pkg::OP_DS: begin
                  cke_r <= 1'b0; // R8 R10
                  cmd_r <= sps_pkg::CMD_BST;
                  deep_r <= 1'b1;
               end
               sps_pkg::OP_WAKE: begin
                  cke_r <= 1'b1; // R7 R11
                  pd_r <= 1'b0;
                  if (deep_r) begin
                     deep_r <= 1'b0;
                     busy_r <= 1'b1;
                     wait_r <= 32'(DS_EXIT_CYC); // R12
                  end
               end
               default: cmd_r <= sps_pkg::CMD_NOP;
            endcase
         end
      end
   end
   // power-down residency watchdog
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         pd_cnt_r <= '0;
         pd_overrun_r <= 1'b0;
      end else if (!pd_r) begin
         pd_cnt_r <= '0;
      end else if (pd_cnt_r == 32'(REFRESH_PERIOD_CYC)) begin
         pd_overrun_r <= 1'b1; // R6
      end else begin
         pd_cnt_r <= pd_cnt_r + 1'b1;
      end
   end
   // read data capture
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         rdata_r <= '0;
      end else if (!pins.dq_oe_n) begin
         rdata_r <= pins.dq_from_dev;
      end
   end
   assign pins.cke = cke_r;
   assign {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} = cmd_r;
   assign pins.bank_sel = bank_r;
   assign pins.addr = a_r;
   assign pins.dqm = dqm_r;
   assign pins.dq_to_dev = dq_r;
endmodule // sps_ctrl
`default_nettype wire

//--- tb/sps_chk_sva.sv
// checker: power-state and precharge properties on the sdram pins
`default_nettype none
module sps_chk_sva (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // pins and device state
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [12:0] addr,
   input wire logic dq_oe_n,
   input wire logic [1:0] pwr_state,
   input wire logic [7:0] bank_state,
   input wire logic array_lost
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   wire [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
   // some bank is reading or writing
   wire busy = bank_state[7] | bank_state[5] | bank_state[3] | bank_state[1];
   sequence s_run;
      pwr_state == sps_pkg::PW_RUN;
   endsequence
   sequence s_cke_fall;
      $past(cke) && !cke;
   endsequence
   // pwr_state and bank_state are registered copies, one edge behind
   a_pd_enter: assert property (s_run ##0 s_cke_fall ##0
      (cmd == sps_pkg::CMD_NOP && !busy)
      |-> ##2 pwr_state == sps_pkg::PW_DOWN)
      else $error("power-down not entered");
   a_pd_exit: assert property (pwr_state == sps_pkg::PW_DOWN && cke &&
      cmd == sps_pkg::CMD_NOP |-> ##2 s_run)
      else $error("power-down not left");
   a_pd_quiet: assert property (pwr_state == sps_pkg::PW_DOWN |-> dq_oe_n)
      else $error("data driven in power-down");
   a_ds_enter: assert property (s_run ##0 s_cke_fall ##0
      (cmd == sps_pkg::CMD_BST && bank_state == 8'h00)
      |-> ##2 pwr_state == sps_pkg::PW_DEEP)
      else $error("deep sleep missed");
   a_ds_lost: assert property (pwr_state == sps_pkg::PW_DEEP |=> array_lost)
      else $error("array not marked lost");
   a_susp_enter: assert property (s_run ##0 s_cke_fall ##0 busy
      |-> ##2 pwr_state == sps_pkg::PW_SUSP) else $error("suspend missed");
   a_susp_hold: assert property (pwr_state == sps_pkg::PW_SUSP && !cke
      |=> $stable(bank_state)) else $error("bank state moved in suspend");
   a_susp_exit: assert property (pwr_state == sps_pkg::PW_SUSP && cke
      |-> ##[1:2] s_run) else $error("suspend not left");
   a_pre_all: assert property (s_run ##0 (cke && cmd == sps_pkg::CMD_PRE &&
      addr[sps_pkg::ALL_BANK_BIT]) |-> ##[1:3] bank_state == 8'h00)
      else $error("banks open");
endmodule // sps_chk_sva
`default_nettype wire

//--- tb/tb.sv
// testbench: avalon-driven controller joined to the device
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, nrst, avs_read, avs_write, avs_waitrequest, pd_act, lost;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [1:0] pwr_state;
   logic [7:0] bank_state;
   logic [15:0] rnd;
   int bad_count, num_checks, cyc;
   int mem[int];
   sps_if #(.DW(16)) pins ();
   sps_ctrl #(.DW(16), .DS_EXIT_CYC(20), .REFRESH_PERIOD_CYC(100)) i_sps_ctrl (
      .ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .pins(pins.ctrl));
   sps_device i_sps_device (.ref_clk(ref_clk),
      .nrst(nrst), .pins(pins.dev), .pwr_state(pwr_state),
      .bank_state(bank_state), .power_down_active(pd_act), .array_lost(lost));
   sps_chk_sva i_chk (.ref_clk(ref_clk), .nrst(nrst), .cke(pins.cke),
      .cs_n(pins.cs_n), .ras_n(pins.ras_n), .cas_n(pins.cas_n),
      .we_n(pins.we_n), .addr(pins.addr), .dq_oe_n(pins.dq_oe_n),
      .pwr_state(pwr_state), .bank_state(bank_state), .array_lost(lost));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // one avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic op(input logic [3:0] code, input logic [14:0] a);
      bus(1'b1, sps_pkg::REG_ADDR, {17'h0_0000, a});
      bus(1'b1, sps_pkg::REG_CMD, {28'h000_0000, code});
   endtask
   task automatic st(input int b, input logic e);
      bus(1'b0, sps_pkg::REG_STATUS, 32'h0000_0000);
      chk({31'h0000_0000, q[b]}, {31'h0000_0000, e});
   endtask
   // descending single writes, then read bursts; the controller keeps
   // the last beat, which lies burst_length - 1 columns on
   task automatic wrrd();
      op(sps_pkg::OP_ACT, 15'h0000);
      for (int i = sps_pkg::BURST_LENGTH + 2; i >= 0; i--) begin
         rnd = lfsr(rnd);
         mem[i] = int'(rnd);
         bus(1'b1, sps_pkg::REG_WDATA, {16'h0000, rnd});
         op(sps_pkg::OP_WR, 15'(i));
      end
      for (int i = 0; i < 4; i++) begin
         op(sps_pkg::OP_RD, 15'(i));
         repeat (8) @(posedge ref_clk);
         bus(1'b0, sps_pkg::REG_RDATA, 32'h0000_0000);
         chk(q, 32'(mem[i + sps_pkg::BURST_LENGTH - 1]));
      end
      $display("test write-read done");
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         end_sim();
      end
   end
   initial begin
      {nrst, avs_read, avs_write, avs_address, avs_writedata} = '0;
      {bad_count, num_checks, cyc} = '0;
      rnd = 16'hafd5;
      repeat (3) @(posedge ref_clk);
      nrst <= 1'b1;
      bus(1'b0, 4'h2, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      st(1, 1'b0);
      $display("test registers done");
      op(sps_pkg::OP_MODE, 15'h0200);
      wrrd();
      op(sps_pkg::OP_RD, 15'h0000);
      bus(1'b1, sps_pkg::REG_CMD, {28'h000_0000, sps_pkg::OP_SUSP});
      repeat (3) @(posedge ref_clk);
      op(sps_pkg::OP_WAKE, 15'h0000);
      repeat (8) @(posedge ref_clk);
      op(sps_pkg::OP_PD, 15'h0000);
      st(1, 1'b1);
      chk({31'h0000_0000, pd_act}, 32'h0000_0001);
      repeat (120) @(posedge ref_clk);
      st(3, 1'b1);
      op(sps_pkg::OP_WAKE, 15'h0000);
      st(1, 1'b0);
      $display("test active power-down done");
      op(sps_pkg::OP_PRE, 15'h0400);
      repeat (3) @(posedge ref_clk);
      chk({24'h00_0000, bank_state}, 32'h0000_0000);
      op(sps_pkg::OP_PD, 15'h0000);
      st(1, 1'b1);
      chk({31'h0000_0000, pd_act}, 32'h0000_0000);
      op(sps_pkg::OP_WAKE, 15'h0000);
      op(sps_pkg::OP_DS, 15'h0000);
      st(0, 1'b1);
      chk({31'h0000_0000, lost}, 32'h0000_0001);
      op(sps_pkg::OP_WAKE, 15'h0000);
      st(0, 1'b0);
      op(sps_pkg::OP_PRE, 15'h0400);
      op(sps_pkg::OP_REF, 15'h0000);
      op(sps_pkg::OP_REF, 15'h0000);
      $display("test deep sleep done");
      wrrd();
      end_sim();
   end
endmodule // tb
`default_nettype wire
